// >>> logic/spis_map.vh
// spis_map.vh: register offsets, field positions, reset values
// assumes inclusion by spis_core, the monitor and the testbench
`ifndef SPIS_MAP_VH
`define SPIS_MAP_VH

// register byte offsets on the bus
`define SPIS_OFF_STATUS 8'h00
`define SPIS_OFF_RXBYTE 8'h04
`define SPIS_OFF_TXBYTE 8'h08
`define SPIS_OFF_DIV 8'h0C
`define SPIS_OFF_CTL 8'h10

// reset values
`define SPIS_RST_CTL 16'h0000
`define SPIS_RST_DIV 16'h0000
`define SPIS_RST_STATUS 16'h0000

// port_control fields
`define SPIS_CTL_EN 0
`define SPIS_CTL_MASTER 1
`define SPIS_CTL_CPHA 2
`define SPIS_CTL_CPOL 3
`define SPIS_CTL_WOM 4
`define SPIS_CTL_LSB 5
`define SPIS_CTL_TIM 6
`define SPIS_CTL_ZEN 7
`define SPIS_CTL_RXOVW 8
`define SPIS_CTL_OEN 9
`define SPIS_CTL_CON 11
`define SPIS_CTL_RECEIVE_FLUSH_BIT 12
`define SPIS_CTL_TRANSMIT_FLUSH_BIT 13
`define SPIS_CTL_MODLO 14
`define SPIS_CTL_MODHI 15

// baud_divider fields
`define SPIS_DIV_BIT_COUNTER_RESET_ON_ERROR 7
`define SPIS_DIV_WMASK 16'h00BF

// port_status fields
`define SPIS_STA_IRQ 0
`define SPIS_STA_TRANSMIT_UNDERRUN_FLAG 4
`define SPIS_STA_TX 5
`define SPIS_STA_RX 6
`define SPIS_STA_RECEIVE_OVERFLOW_FLAG 7
`define SPIS_STA_RXS 11
`define SPIS_STA_CHIP_SELECT_ERROR_FLAG 12

// serial framing
`define SPIS_BIT_RESET 3'h7
`define SPIS_TOG_LAST 4'hF
`define SPIS_MOD_FULL 2'h3

`endif

// >>> logic/spis_sync.v
// spis_sync.v: two-flop synchroniser for a group of pin levels
// assumes level inputs slower than clk; reset value given by parameter
`default_nettype none

module spis_sync #(
    parameter W = 4,
    parameter [W-1:0] RV = {W{1'b0}}
) (
    input wire clk,
    input wire rst_b,
    input wire [W-1:0] pinLvl,
    output wire [W-1:0] syncLvl
);
    reg [W-1:0] stage1_r;
    reg [W-1:0] stage2_r;

    // first stage feeds only the second stage
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_r <= RV;
            stage2_r <= RV;
        end else begin
            stage1_r <= pinLvl;
            stage2_r <= stage1_r;
        end
    end

    assign syncLvl = stage2_r;
endmodule // spis_sync

`default_nettype wire

// >>> logic/spis_fifo.v
// spis_fifo.v: four-byte fifo with count, flush and overwrite on full
// assumes push and pop are one-cycle strobes on clk
`default_nettype none

module spis_fifo (
    input wire clk,
    input wire rst_b,
    input wire flush,
    input wire push,
    input wire ovw,
    input wire [7:0] pushData,
    input wire pop,
    output wire [7:0] headData,
    output wire [2:0] count,
    output wire full,
    output wire empty
);
    reg [7:0] mem [0:3];
    reg [1:0] wrPtr_r;
    reg [1:0] rdPtr_r;
    reg [2:0] cnt_r;
    wire doPop = pop && (cnt_r != 3'h0);
    wire doPush = push && (!full || ovw);
    wire dropOld = push && full && ovw;

    // pointers and count; overwrite drops the oldest byte
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_r <= 2'h0;
            rdPtr_r <= 2'h0;
            cnt_r <= 3'h0;
        end else if (flush) begin
            wrPtr_r <= 2'h0;
            rdPtr_r <= 2'h0;
            cnt_r <= 3'h0;
        end else begin
            if (doPush)
                wrPtr_r <= wrPtr_r + 2'h1;
            if (doPop || dropOld)
                rdPtr_r <= rdPtr_r + 2'h1;
            if (doPush && !doPop && !full)
                cnt_r <= cnt_r + 3'h1;
            else if (doPop && !doPush)
                cnt_r <= cnt_r - 3'h1;
        end
    end

    // storage
    always @(posedge clk) begin
        if (doPush && !flush)
            mem[wrPtr_r] <= pushData;
    end

    assign headData = (cnt_r == 3'h0) ? 8'h00 : mem[rdPtr_r];
    assign count = cnt_r;
    assign full = (cnt_r == 3'h4);
    assign empty = (cnt_r == 3'h0);
endmodule // spis_fifo

`default_nettype wire

// >>> logic/spis_core.v
// spis_core.v: serial port with flags, wire-or drive (miso driven only low, mosi only high) and cs error check
// assumes an ahb-lite master, pins from another clock domain, clk 10 MHz
`include "spis_map.vh"
`default_nettype none

module spis_core (
    input wire clk,
    input wire rst_b,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    input wire sclkIn,
    output wire sclkOut,
    output wire sclkOeB,
    input wire csBIn,
    output wire csBOut,
    output wire csBOeB,
    input wire mosiIn,
    output wire mosiOut,
    output wire mosiOeB,
    input wire misoIn,
    output wire misoOut,
    output wire misoOeB,
    output wire irq
);
    localparam [1:0] M_IDLE = 2'h0;
    localparam [1:0] M_RUN = 2'h1;
    localparam [1:0] M_STALL = 2'h2;

    // threshold code to byte count
    function [2:0] thrOf;
        input [1:0] code;
        begin
            thrOf = {1'b0, code} + 3'h1;
        end
    endfunction

    reg [15:0] ctl_r;
    reg [15:0] div_r;
    reg [31:0] hrdata_r;
    reg wrPend_r;
    reg [7:0] wrAddr_r;
    reg transmit_underrun_flag_r, txIrq_r, rxIrq_r, receive_overflow_flag_r, chip_select_error_flag_r;
    reg [1:0] txBytes_r;
    reg [2:0] bitCnt_r;
    reg [7:0] txShift_r;
    reg [7:0] rxShift_r;
    reg [7:0] lastTx_r;
    reg haveData_r;
    reg sclkPrev_r;
    reg csPrev_r;
    reg [1:0] mState_r;
    reg [5:0] divCnt_r;
    reg [3:0] togCnt_r;
    reg [2:0] rxLeft_r;
    reg sclkInt_r;
    reg csOut_r;
    reg [15:0] rdMux;

    wire [3:0] pinS;
    wire sclkS = pinS[3];
    wire csS = pinS[2];
    wire mosiS = pinS[1];
    wire misoS = pinS[0];

    wire en = ctl_r[`SPIS_CTL_EN];
    wire master = ctl_r[`SPIS_CTL_MASTER];
    wire cpha = ctl_r[`SPIS_CTL_CPHA];
    wire cpol = ctl_r[`SPIS_CTL_CPOL];
    wire wire_or_mode = ctl_r[`SPIS_CTL_WOM];
    wire lsb = ctl_r[`SPIS_CTL_LSB];
    wire tim = ctl_r[`SPIS_CTL_TIM];
    wire zen = ctl_r[`SPIS_CTL_ZEN];
    wire con = ctl_r[`SPIS_CTL_CON];
    wire receive_flush_bit = ctl_r[`SPIS_CTL_RECEIVE_FLUSH_BIT];
    wire transmit_flush_bit = ctl_r[`SPIS_CTL_TRANSMIT_FLUSH_BIT];
    wire [1:0] mode = ctl_r[`SPIS_CTL_MODHI:`SPIS_CTL_MODLO];
    wire bit_counter_reset_on_error = div_r[`SPIS_DIV_BIT_COUNTER_RESET_ON_ERROR];

    // bus decode: address phase, read side effects, write data phase
    wire addrPhase = hsel && htrans[1] && hready;
    wire rdTake = addrPhase && !hwrite;
    wire stRead = rdTake && (haddr == `SPIS_OFF_STATUS);
    wire rxRead = rdTake && (haddr == `SPIS_OFF_RXBYTE);
    wire ctlWr = wrPend_r && (wrAddr_r == `SPIS_OFF_CTL);
    wire divWr = wrPend_r && (wrAddr_r == `SPIS_OFF_DIV);
    wire txWr = wrPend_r && (wrAddr_r == `SPIS_OFF_TXBYTE) && !transmit_flush_bit;

    // fifos
    wire [7:0] txHead, rxHead;
    wire [2:0] txCnt, rxCnt;
    wire txFull, txEmpty, rxFull, rxEmpty;
    wire txPop, rxPush;
    wire [7:0] rxByte;

    // serial events shared by master and slave
    wire tick = (divCnt_r == div_r[5:0]);
    wire mRun = (mState_r == M_RUN);
    wire lastTog = mRun && tick && (togCnt_r == `SPIS_TOG_LAST);
    wire moreBytes = tim ? !txEmpty : (rxLeft_r != 3'h0);
    wire startReq = en && master && moreBytes;
    wire stallEnd = (mState_r == M_STALL) && tick && togCnt_r[0];
    wire startByte = ((mState_r == M_IDLE) && startReq) ||
        (lastTog && moreBytes && con) || (stallEnd && moreBytes);
    wire leadM = mRun && tick && (sclkInt_r == cpol);
    wire trailM = mRun && tick && (sclkInt_r != cpol);
    wire csAct = en && !master && !csS;
    wire sclkRise = sclkS && !sclkPrev_r;
    wire sclkFall = !sclkS && sclkPrev_r;
    wire leadS = csAct && (cpol ? sclkFall : sclkRise);
    wire trailS = csAct && (cpol ? sclkRise : sclkFall);
    wire lead = master ? leadM : leadS;
    wire trail = master ? trailM : trailS;
    wire sampleEv = cpha ? trail : lead;
    wire shiftEv = cpha ? lead : trail;
    wire byteDone = en && sampleEv && (bitCnt_r == 3'h0);
    wire csEff = master ? csOut_r : csS;
    wire csRise = csEff && !csPrev_r;
    wire csFall = !csEff && csPrev_r;
    wire loadS = en && !master &&
        (csFall || (shiftEv && bitCnt_r == `SPIS_BIT_RESET));
    wire loadEv = master ? startByte : loadS;
    wire underrunEv = master ? (startByte && txEmpty) :
        (sampleEv && bitCnt_r == `SPIS_BIT_RESET && !haveData_r);
    wire rxBit = master ? misoS : mosiS;
    wire txBit = lsb ? txShift_r[0] : txShift_r[7];
    wire cserrEv = en && csRise && (bitCnt_r != `SPIS_BIT_RESET);

    assign txPop = master ? (startByte && !txEmpty) :
        (byteDone && haveData_r);
    assign rxPush = byteDone && !receive_flush_bit;
    assign rxByte = lsb ? {rxBit, rxShift_r[7:1]} : {rxShift_r[6:0], rxBit};

    // flag set terms
    wire rxWritten = rxPush && (!rxFull || ctl_r[`SPIS_CTL_RXOVW]);
    wire [2:0] rxCntNext = rxFull ? 3'h4 : rxCnt + 3'h1;
    wire setTx = byteDone && tim && !transmit_flush_bit &&
        (txBytes_r == mode);
    wire setRx = rxWritten && !tim &&
        (rxCntNext >= thrOf(mode));
    wire setTxur = en && underrunEv && !transmit_flush_bit;
    wire setRxof = rxPush && rxFull;
    wire clrAll = stRead || !en;
    wire excess = (mode != `SPIS_MOD_FULL) &&
        (rxCnt > thrOf(mode));
    wire anyFlag = transmit_underrun_flag_r | txIrq_r | rxIrq_r | receive_overflow_flag_r | chip_select_error_flag_r;

    spis_sync #(.W(4), .RV(4'h4)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pinLvl({sclkIn, csBIn, mosiIn, misoIn}),
        .syncLvl(pinS)
    );

    spis_fifo u_txFifo (
        .clk(clk),
        .rst_b(rst_b),
        .flush(transmit_flush_bit),
        .push(txWr),
        .ovw(1'b1),
        .pushData(hwdata[7:0]),
        .pop(txPop),
        .headData(txHead),
        .count(txCnt),
        .full(txFull),
        .empty(txEmpty)
    );

    spis_fifo u_rxFifo (
        .clk(clk),
        .rst_b(rst_b),
        .flush(receive_flush_bit),
        .push(rxPush),
        .ovw(ctl_r[`SPIS_CTL_RXOVW]),
        .pushData(rxByte),
        .pop(rxRead),
        .headData(rxHead),
        .count(rxCnt),
        .full(rxFull),
        .empty(rxEmpty)
    );

    // register read view
    always @* begin
        rdMux = 16'h0000;
        case (haddr)
            `SPIS_OFF_STATUS: begin
                rdMux[`SPIS_STA_IRQ] = anyFlag;
                rdMux[3:1] = txCnt;
                rdMux[`SPIS_STA_TRANSMIT_UNDERRUN_FLAG] = transmit_underrun_flag_r;
                rdMux[`SPIS_STA_TX] = txIrq_r;
                rdMux[`SPIS_STA_RX] = rxIrq_r;
                rdMux[`SPIS_STA_RECEIVE_OVERFLOW_FLAG] = receive_overflow_flag_r;
                rdMux[10:8] = rxCnt;
                rdMux[`SPIS_STA_RXS] = excess;
                rdMux[`SPIS_STA_CHIP_SELECT_ERROR_FLAG] = chip_select_error_flag_r;
            end
            `SPIS_OFF_RXBYTE: rdMux = {8'h00, rxHead};
            `SPIS_OFF_DIV: rdMux = div_r;
            `SPIS_OFF_CTL: rdMux = ctl_r;
            default: rdMux = 16'h0000;
        endcase
    end

    // bus slave: read data captured at the address phase edge
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata_r <= 32'h00000000;
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
        end else begin
            wrPend_r <= addrPhase && hwrite;
            if (addrPhase)
                wrAddr_r <= haddr;
            if (rdTake)
                hrdata_r <= {16'h0000, rdMux};
        end
    end

    // a read behind a pending write waits one cycle
    assign hreadyout = !(wrPend_r && hsel && htrans[1] && !hwrite);
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // software registers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_r <= `SPIS_RST_CTL;
            div_r <= `SPIS_RST_DIV;
        end else begin
            if (ctlWr)
                ctl_r <= hwdata[15:0];
            if (divWr)
                div_r <= hwdata[15:0] & `SPIS_DIV_WMASK;
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            transmit_underrun_flag_r <= 1'b0;
            txIrq_r <= 1'b0;
            rxIrq_r <= 1'b0;
            receive_overflow_flag_r <= 1'b0;
            chip_select_error_flag_r <= 1'b0;
        end else begin
            txIrq_r <= setTx | (txIrq_r & !clrAll & !transmit_flush_bit);
            transmit_underrun_flag_r <= setTxur | (transmit_underrun_flag_r & !clrAll & !transmit_flush_bit);
            rxIrq_r <= setRx | (rxIrq_r & !clrAll & !receive_flush_bit);
            receive_overflow_flag_r <= setRxof | (receive_overflow_flag_r & !clrAll & !receive_flush_bit);
            chip_select_error_flag_r <= cserrEv | (chip_select_error_flag_r & !clrAll);
        end
    end

    // transmitted-byte counter toward the tx threshold
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            txBytes_r <= 2'h0;
        else if (ctlWr || !en)
            txBytes_r <= 2'h0;
        else if (byteDone)
            txBytes_r <= (txBytes_r == mode) ? 2'h0 : txBytes_r + 2'h1;
    end

    // bit counter, shifters and edge history
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bitCnt_r <= `SPIS_BIT_RESET;
            txShift_r <= 8'h00;
            rxShift_r <= 8'h00;
            lastTx_r <= 8'h00;
            haveData_r <= 1'b0;
            sclkPrev_r <= 1'b0;
            csPrev_r <= 1'b1;
        end else begin
            sclkPrev_r <= sclkS;
            csPrev_r <= csEff;
            if (!en || (cserrEv && bit_counter_reset_on_error))
                bitCnt_r <= `SPIS_BIT_RESET;
            else if (sampleEv)
                bitCnt_r <= bitCnt_r - 3'h1;
            if (sampleEv)
                rxShift_r <= rxByte;
            if (loadEv) begin
                // with no byte waiting, load zero when zen is set, else repeat lastTx_r
                txShift_r <= txEmpty ? (zen ? 8'h00 : lastTx_r) : txHead;
                haveData_r <= !txEmpty;
                if (!txEmpty)
                    lastTx_r <= txHead;
            end else if (shiftEv && bitCnt_r != `SPIS_BIT_RESET) begin
                txShift_r <= lsb ? {1'b0, txShift_r[7:1]} :
                    {txShift_r[6:0], 1'b0};
            end
            if (byteDone && !master && !loadEv)
                haveData_r <= 1'b0;
        end
    end

    // master clock generator and byte sequencer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mState_r <= M_IDLE;
            divCnt_r <= 6'h00;
            togCnt_r <= 4'h0;
            sclkInt_r <= 1'b0;
            csOut_r <= 1'b1;
            rxLeft_r <= 3'h0;
        end else if (!en || !master) begin
            mState_r <= M_IDLE;
            divCnt_r <= 6'h00;
            togCnt_r <= 4'h0;
            sclkInt_r <= cpol;
            csOut_r <= 1'b1;
            rxLeft_r <= 3'h0;
        end else begin
            divCnt_r <= (tick || mState_r == M_IDLE) ? 6'h00 :
                divCnt_r + 6'h01;
            if (rxRead && !tim && mState_r == M_IDLE)
                rxLeft_r <= thrOf(mode);
            else if (startByte && !tim && rxLeft_r != 3'h0)
                rxLeft_r <= rxLeft_r - 3'h1;
            case (mState_r)
                M_IDLE: begin
                    sclkInt_r <= cpol;
                    togCnt_r <= 4'h0;
                    if (startReq) begin
                        mState_r <= M_RUN;
                        csOut_r <= 1'b0;
                    end
                end
                M_RUN: begin
                    if (tick) begin
                        sclkInt_r <= !sclkInt_r;
                        togCnt_r <= togCnt_r + 4'h1;
                    end
                    if (lastTog && !(moreBytes && con)) begin
                        mState_r <= moreBytes ? M_STALL : M_IDLE;
                        csOut_r <= 1'b1;
                    end
                end
                M_STALL: begin
                    if (tick)
                        togCnt_r <= togCnt_r + 4'h1;
                    if (stallEnd) begin
                        togCnt_r <= 4'h0;
                        mState_r <= moreBytes ? M_RUN : M_IDLE;
                        csOut_r <= !moreBytes;
                    end
                end
                default: begin
                    mState_r <= M_IDLE;
                    csOut_r <= 1'b1;
                end
            endcase
        end
    end

    // pin drivers, enables active low
    assign sclkOut = sclkInt_r;
    assign sclkOeB = !(en && master);
    assign csBOut = csOut_r;
    assign csBOeB = !(en && master);
    assign mosiOut = txBit;
    assign mosiOeB = !(en && master && (!wire_or_mode || txBit));
    assign misoOut = txBit;
    assign misoOeB = !(csAct && ctl_r[`SPIS_CTL_OEN] &&
        (!wire_or_mode || !txBit));
    assign irq = anyFlag;
endmodule // spis_core

`default_nettype wire

// >>> tb/spis_monitor.sv
// spis_monitor.sv: port-level checker bound into spis_core
// assumes hready tied to hreadyout and a single core instance
`include "spis_map.vh"
`default_nettype none

module spis_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic sclkOut,
    input wire logic csBOut,
    input wire logic csBOeB,
    input wire logic mosiOut,
    input wire logic mosiOeB,
    input wire logic misoOut,
    input wire logic misoOeB,
    input wire logic irq
);
    logic wrCtl_r;
    logic rdSta_r;
    logic sclkPrev_r;
    logic [1:0] age_r;
    logic [3:0] rise_r;
    logic [15:0] ctl_r;
    wire logic taken = hsel & htrans[1] & hready;
    wire logic rdEnd = rdSta_r & hready;
    wire logic wire_or_mode = age_r == 2'h3 && ctl_r[4] && ctl_r[0];

    // follow control writes and status reads, count serial clock rises
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrCtl_r <= 1'b0;
            rdSta_r <= 1'b0;
            sclkPrev_r <= 1'b0;
            age_r <= 2'h0;
            rise_r <= 4'h0;
            ctl_r <= 16'h0000;
        end else begin
            sclkPrev_r <= sclkOut;
            if (hready) begin
                wrCtl_r <= taken & hwrite & (haddr == `SPIS_OFF_CTL);
                rdSta_r <= taken & !hwrite & (haddr == `SPIS_OFF_STATUS);
            end
            if (hready & wrCtl_r) begin
                ctl_r <= hwdata[15:0];
                age_r <= 2'h0;
            end else if (age_r != 2'h3) begin
                age_r <= age_r + 2'h1;
            end
            if (csBOut) begin
                rise_r <= 4'h0;
            end else if (sclkOut & !sclkPrev_r) begin
                rise_r <= rise_r + 4'h1;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_readIrq; rdEnd |-> hrdata[0] == $past(irq); endproperty
    a_readIrq: assert property (p_readIrq) else $error("irq bit");
    property p_irqOr; rdEnd |-> hrdata[0] == |{hrdata[12], hrdata[7:4]}; endproperty
    a_irqOr: assert property (p_irqOr) else $error("irq or");
    property p_rxCount; rdEnd |-> hrdata[10:8] <= 3'h4; endproperty
    a_rxCount: assert property (p_rxCount) else $error("rx count");
    property p_excess;
        rdEnd && hrdata[11] && age_r == 2'h3
            |-> hrdata[10:8] >= 3'h2 && ctl_r[15:14] != 2'h3;
    endproperty
    a_excess: assert property (p_excess) else $error("excess");
    property p_clrOff; wrCtl_r && hready && !hwdata[0] |-> ##[1:3] !irq; endproperty
    a_clrOff: assert property (p_clrOff) else $error("irq kept");
    property p_womMosi; wire_or_mode && ctl_r[1] && !mosiOut |-> mosiOeB; endproperty
    a_womMosi: assert property (p_womMosi) else $error("mosi");
    property p_womMiso; wire_or_mode && !ctl_r[1] && misoOut |-> misoOeB; endproperty
    a_womMiso: assert property (p_womMiso) else $error("miso");
    property p_eightClk; !csBOeB && $rose(csBOut) |-> rise_r == 4'h8; endproperty
    a_eightClk: assert property (p_eightClk) else $error("clocks");

    // main scenarios reached
    cover property (rdEnd && hrdata[12]);
    cover property ($rose(irq));
    cover property (!csBOeB && $rose(csBOut));
endmodule // spis_monitor

bind spis_core spis_monitor mon (
    .clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .sclkOut, .csBOut, .csBOeB, .mosiOut, .mosiOeB, .misoOut,
    .misoOeB, .irq
);
`default_nettype wire

// >>> tb/spis_partner.sv
// spis_partner.sv: far-side spi device, slave or master, mode 0, msb first
// assumes pull-ups on chip select and data lines, clock idles low
`default_nettype none

module spis_partner (
    input wire logic beMaster,
    input wire logic sclkOut,
    input wire logic sclkOeB,
    input wire logic csBOut,
    input wire logic csBOeB,
    input wire logic mosiOut,
    input wire logic mosiOeB,
    input wire logic misoOut,
    input wire logic misoOeB,
    output logic sclkLine,
    output logic csBLine,
    output logic mosiLine,
    output logic misoLine
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pSclk = 1'b0;
    logic pCsB = 1'b1;
    logic pMosi = 1'b1;
    logic pMiso = 1'b1;
    logic [7:0] txSr = 8'h00;
    logic [7:0] rxSr = 8'h00;
    logic [7:0] slvTx = 8'h3C;

    // wire levels: enabled driver, else this device, else pull-up, or low for sclkLine
    assign sclkLine = !sclkOeB ? sclkOut : (beMaster & pSclk);
    assign csBLine = !csBOeB ? csBOut : (!beMaster | pCsB);
    assign mosiLine = !mosiOeB ? mosiOut : (!beMaster | pCsB | pMosi);
    assign misoLine = !misoOeB ? misoOut : (beMaster | csBLine | pMiso);

    // slave role: new byte per frame, sample on rise, shift on fall
    always @(negedge csBLine) if (!beMaster) begin
        txSr = slvTx;
        pMiso = slvTx[7];
        slvTx = slvTx + 8'h01;
    end
    always @(posedge sclkLine) if (!csBLine) begin
        rxSr = {rxSr[6:0], beMaster ? misoLine : mosiLine};
    end
    always @(negedge sclkLine) if (!csBLine && !beMaster) begin
        txSr = txSr << 1;
        pMiso = txSr[7];
    end

    // master role: 800 ns serial period, nBits clocks, then release
    task automatic xfer(input logic [7:0] d, input int nBits);
        #37;
        txSr = d;
        pMosi = d[7];
        pCsB = 1'b0;
        #400;
        for (int i = 0; i < nBits; i++) begin
            pSclk = 1'b1;
            #400;
            pSclk = 1'b0;
            txSr = txSr << 1;
            pMosi = txSr[7];
            #400;
        end
        pCsB = 1'b1;
        #800;
    endtask
endmodule // spis_partner
`default_nettype wire

// >>> tb/spi_irq_status_chip_select_error_flag_tb.sv
// spi_irq_status_chip_select_error_flag_tb.sv: register-level tests of spis_core
// assumes spis_partner on the link, spis_monitor bound into the core
`include "spis_map.vh"
`default_nettype none
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            failures++; \
            $display("BAD t=%0t got %0h exp %0h", $time, g, e); \
        end \
    end

module spi_irq_status_chip_select_error_flag_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic beMaster = 1'b0;
    logic [31:0] rv;
    int failures = 0;
    int check_count = 0;
    wire logic hreadyout, hresp, sclkOut, sclkOeB, csBOut, csBOeB;
    wire logic mosiOut, mosiOeB, misoOut, misoOeB, irq;
    wire logic sclkLine, csBLine, mosiLine, misoLine;
    wire logic [31:0] hrdata;

    spis_core DUT (
        .clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .sclkIn(sclkLine), .sclkOut, .sclkOeB, .csBIn(csBLine), .csBOut,
        .csBOeB, .mosiIn(mosiLine), .mosiOut, .mosiOeB, .misoIn(misoLine),
        .misoOut, .misoOeB, .irq
    );
    spis_partner peer (
        .beMaster, .sclkOut, .sclkOeB, .csBOut, .csBOeB, .mosiOut,
        .mosiOeB, .misoOut, .misoOeB, .sclkLine, .csBLine, .mosiLine,
        .misoLine
    );

    always #50 clk = ~clk;

    // one single ahb-lite transfer, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, {16'h0000, d}, rv);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e);
        bus(1'b0, a, 32'h0, rv);
        `CHK(rv & m, e)
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic sx(input logic [7:0] d, input int n);
        peer.xfer(d, n);
        @(posedge clk);
    endtask
    task automatic results;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard, far beyond the thousand or so cycles the tests take
    initial begin
        #2000000;
        failures++;
        results;
    end

    // main sequence: map, master transfers, slave transfers
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rc(8'(i * 4), 32'hFFFF_FFFF, 32'h0);
        end
        wr(`SPIS_OFF_DIV, 16'hFFFF);
        rc(`SPIS_OFF_DIV, 32'hFFFF_FFFF, 32'h00BF);
        wr(`SPIS_OFF_DIV, 16'h0083);
        $display("test map done");
        wr(`SPIS_OFF_CTL, 16'h4043);
        wr(`SPIS_OFF_TXBYTE, 16'h00A5);
        idle(80);
        `CHK(peer.rxSr, 8'hA5)
        rc(`SPIS_OFF_STATUS, 32'h0721, 32'h0100);
        wr(`SPIS_OFF_CTL, 16'h4043);
        wr(`SPIS_OFF_TXBYTE, 16'h005A);
        idle(80);
        rc(`SPIS_OFF_STATUS, 32'h0020, 32'h0);
        wr(`SPIS_OFF_TXBYTE, 16'h00C3);
        wr(`SPIS_OFF_TXBYTE, 16'h0096);
        rc(`SPIS_OFF_STATUS, 32'h000E, 32'h0002);
        idle(160);
        rc(`SPIS_OFF_STATUS, 32'h0FA1, 32'h0C21);
        rc(`SPIS_OFF_STATUS, 32'h0820, 32'h0800);
        `CHK(peer.rxSr, 8'h96)
        wr(`SPIS_OFF_TXBYTE, 16'h0011);
        idle(80);
        rc(`SPIS_OFF_STATUS, 32'h0781, 32'h0481);
        rc(`SPIS_OFF_RXBYTE, 32'hFFFF, 32'h003C);
        wr(`SPIS_OFF_CTL, 16'h5043);
        wr(`SPIS_OFF_TXBYTE, 16'h0022);
        idle(80);
        rc(`SPIS_OFF_STATUS, 32'h07C0, 32'h0);
        wr(`SPIS_OFF_CTL, 16'h4053);
        wr(`SPIS_OFF_TXBYTE, 16'h00F0);
        idle(80);
        `CHK(peer.rxSr, 8'hFF)
        wr(`SPIS_OFF_CTL, 16'h2083);
        rc(`SPIS_OFF_RXBYTE, 32'hFFFF, 32'h0042);
        idle(80);
        rc(`SPIS_OFF_STATUS, 32'h0771, 32'h0141);
        `CHK(peer.rxSr, 8'h00)
        wr(`SPIS_OFF_CTL, 16'h1000);
        idle(3);
        `CHK(irq, 1'b0)
        $display("test master done");
        beMaster <= 1'b1;
        wr(`SPIS_OFF_CTL, 16'h0201);
        sx(8'h69, 8);
        rc(`SPIS_OFF_STATUS, 32'h17F1, 32'h0151);
        rc(`SPIS_OFF_STATUS, 32'h1071, 32'h0);
        rc(`SPIS_OFF_RXBYTE, 32'hFFFF, 32'h0069);
        sx(8'hFF, 3);
        rc(`SPIS_OFF_STATUS, 32'h1001, 32'h1001);
        wr(`SPIS_OFF_DIV, 16'h0003);
        sx(8'hFF, 3);
        `CHK(irq, 1'b1)
        sx(8'h50, 5);
        rc(`SPIS_OFF_RXBYTE, 32'hFFFF, 32'h00EA);
        wr(`SPIS_OFF_DIV, 16'h0083);
        wr(`SPIS_OFF_CTL, 16'h0000);
        idle(3);
        `CHK(irq, 1'b0)
        wr(`SPIS_OFF_CTL, 16'h0211);
        wr(`SPIS_OFF_TXBYTE, 16'h003E);
        sx(8'h81, 8);
        `CHK(peer.rxSr, 8'h3E)
        rc(`SPIS_OFF_RXBYTE, 32'hFFFF, 32'h0081);
        rc(`SPIS_OFF_STATUS, 32'h1010, 32'h0);
        $display("test slave done");
        results;
    end
endmodule // spi_irq_status_chip_select_error_flag_tb
`default_nettype wire
